// File: core/rcmr_pkg.sv
// Package of constants and types for the reset cause and memory remap block
package rcmr_pkg;
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 100; // 10 MHz system clock
	localparam int unsigned RST_HOLD_NS = 1000; // Least time the system reset is held
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up
	localparam int unsigned HOLD_CNT_W = 8; // Width of the hold counter

	// Register byte offsets
	localparam logic [7:0] REG_MIRROR = 8'h00; // bottom_mirror_select
	localparam logic [7:0] REG_CAUSE = 8'h04; // reset_cause_flags
	localparam logic [7:0] REG_CAUSE_CLR = 8'h08; // reset_cause_clear
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C; // Sticky event status
	localparam logic [7:0] REG_IRQ_MASK = 8'h10; // Event mask

	// Field positions
	localparam int unsigned MIRROR_SRAM_BIT = 0; // 1 = SRAM at the bottom
	localparam int unsigned CAUSE_POR_BIT = 0; // Power-on flag
	localparam int unsigned CAUSE_WDOG_BIT = 1; // Watchdog flag
	localparam int unsigned CAUSE_SW_BIT = 2; // Software reset flag
	localparam int unsigned CAUSE_W = 3; // Implemented cause bits
	localparam int unsigned EVT_USER_BIT = 0; // Handover to user code
	localparam int unsigned EVT_FAULT_BIT = 1; // Hidden or unmapped access
	localparam int unsigned EVT_RST_BIT = 2; // A reset sequence started
	localparam int unsigned EVT_W = 3; // Event bits

	// Reset values
	localparam logic [CAUSE_W-1:0] CAUSE_POR_VAL = 3'h1; // Only the power-on flag
	localparam logic [EVT_W-1:0] EVT_RST_VAL = 3'h0; // Status and mask clear

	// Memory map defaults (byte addresses)
	localparam logic [31:0] VEC_TOP = 32'h00000020; // Exception vectors end
	localparam logic [31:0] MIRROR_BYTES = 32'h00010000; // Size of the mirrored bottom
	localparam logic [31:0] SRAM_BASE = 32'h00010000; // SRAM at its own address
	localparam logic [31:0] SRAM_BYTES = 32'h00002000; // SRAM size
	localparam logic [31:0] FLASH_BASE = 32'h00080000; // Flash at its upper address
	localparam logic [31:0] FLASH_BYTES = 32'h00010000; // Flash size
	localparam logic [31:0] KERNEL_BASE = 32'h000F0000; // Hidden configuration code
	localparam logic [31:0] KERNEL_BYTES = 32'h00000800; // Hidden region size
	localparam logic [31:0] RESET_VECTOR = 32'h00000000; // Jump target after kernel

	// Sequencer states
	typedef enum logic [1:0] {
		RCMR_HOLD,
		RCMR_KERNEL,
		RCMR_USER
	} rcmr_seq_t;

	// Registered decode answer for one core access
	typedef struct packed {
		logic sel_flash; // Flash selected
		logic sel_sram; // SRAM selected
		logic sel_kernel; // Hidden code selected
		logic fault; // Access refused
		logic [31:0] off; // Offset inside the selected memory
	} rcmr_dec_t;
endpackage : rcmr_pkg

// File: core/rcmr_top.sv
// Reset cause recorder, reset sequencer and bottom memory remap decoder
//
// Functional notes
// - Exception vectors live in the bottom region.
// - Every reset mirrors flash, clears select bit.
// - Select bit one puts SRAM at bottom.
// - Select bit zero restores flash at bottom.
// - Start in kernel, then jump to zero.
// - Kernel region hidden from user code.
// - Four reset sources, flags kept until cleared.
// - Power-on reset sets cause bit zero.
// - Watchdog reset sets cause bit one.
// - Writing cause bit two forces software reset.
// - Flags clear only through the clear register or power-on reset.
// - External reset sets no flag at all.
// - Cause bits seven to three read zero.
`timescale 1ns/1ps
`default_nettype none
module rcmr_top #(
	parameter logic [31:0] MIRROR_BYTES = rcmr_pkg::MIRROR_BYTES, // Mirrored bottom size
	parameter int unsigned HOLD_CYC = rcmr_pkg::RST_HOLD_CYC // System reset hold length
) (
	input wire logic clk, // 10 MHz clock
	input wire logic rst_b, // Power-on reset, synchronous
	input wire logic ext_rst_b, // External reset pin
	input wire logic wdog_expire, // Watchdog timeout pulse
	input wire logic boot_mode_pin, // High selects normal boot
	input wire logic kernel_done, // Kernel finished its setup
	input wire logic [7:0] bus_addr, // Register byte address
	input wire logic [31:0] bus_wdata, // Register write data
	input wire logic bus_wr, // Write strobe
	input wire logic bus_rd, // Read strobe
	output logic [31:0] bus_rdata_r, // Read data, one cycle later
	input wire logic cpu_req, // Core access valid
	input wire logic [31:0] cpu_addr, // Core access address
	output rcmr_pkg::rcmr_dec_t dec_r, // Registered decode answer
	output logic sys_rst_b_r, // System reset to core
	output logic kernel_mode_r, // Core runs hidden code
	output logic vec_jump_r, // Pulse: jump to reset vector
	output logic irq_r // Level interrupt
);
	localparam int unsigned HOLD_CNT_W_L = rcmr_pkg::HOLD_CNT_W; // Counter width
	localparam logic [HOLD_CNT_W_L-1:0] HOLD_LOAD = HOLD_CNT_W_L'(HOLD_CYC - 1); // Counter load

	rcmr_pkg::rcmr_seq_t seq_r; // Sequencer state
	logic [HOLD_CNT_W_L-1:0] hold_cnt_r; // Cycles left in hold
	logic mirror_r; // SRAM mirrored at bottom
	logic [rcmr_pkg::CAUSE_W-1:0] cause_r; // Reset cause flags
	logic [rcmr_pkg::EVT_W-1:0] evt_stat_r; // Sticky events
	logic [rcmr_pkg::EVT_W-1:0] evt_mask_r; // Event mask
	logic [rcmr_pkg::EVT_W-1:0] evt_set; // Events this cycle
	logic [rcmr_pkg::CAUSE_W-1:0] cause_nxt; // Next cause flags
	logic sw_rst_req; // Software reset write
	logic clr_wr; // Write to clear register
	logic rst_trig; // Any non power-on reset source
	rcmr_pkg::rcmr_dec_t dec_nxt; // Decode of this access

	// Range test shared by every window of the map
	function automatic logic in_win(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
		in_win = (a >= base) && ((a - base) < size);
	endfunction : in_win

	// Decoder: bottom window follows the select bit, kernel is hidden
	function automatic rcmr_pkg::rcmr_dec_t decode(input logic [31:0] a, input logic sram_sel, input logic kmode,
			input logic [31:0] mbytes);
		rcmr_pkg::rcmr_dec_t d;
		d = '0;
		if (in_win(a, 32'h00000000, mbytes)) begin // Bottom incl. vectors
			d.sel_sram = sram_sel;
			d.sel_flash = !sram_sel;
			d.off = a;
			d.fault = sram_sel && (a >= rcmr_pkg::SRAM_BYTES); // SRAM smaller than the window
		end else if (in_win(a, rcmr_pkg::SRAM_BASE, rcmr_pkg::SRAM_BYTES)) begin
			d.sel_sram = 1'b1;
			d.off = a - rcmr_pkg::SRAM_BASE;
		end else if (in_win(a, rcmr_pkg::FLASH_BASE, rcmr_pkg::FLASH_BYTES)) begin
			d.sel_flash = 1'b1;
			d.off = a - rcmr_pkg::FLASH_BASE;
		end else if (in_win(a, rcmr_pkg::KERNEL_BASE, rcmr_pkg::KERNEL_BYTES) && kmode) begin
			d.sel_kernel = 1'b1;
			d.off = a - rcmr_pkg::KERNEL_BASE;
		end else begin // Hidden region from user code, or unmapped
			d.fault = 1'b1;
		end
		decode = d;
	endfunction : decode

	// Strobe decode
	assign sw_rst_req = bus_wr && (bus_addr == rcmr_pkg::REG_CAUSE) && bus_wdata[rcmr_pkg::CAUSE_SW_BIT];
	assign clr_wr = bus_wr && (bus_addr == rcmr_pkg::REG_CAUSE_CLR);
	assign rst_trig = !ext_rst_b || wdog_expire || sw_rst_req;

	// Cause flags next value: clear first, then set, so a set wins
	always_comb begin
		cause_nxt = cause_r;
		if (clr_wr) begin
			cause_nxt = cause_nxt & ~bus_wdata[rcmr_pkg::CAUSE_W-1:0];
		end
		if (wdog_expire) begin
			cause_nxt[rcmr_pkg::CAUSE_WDOG_BIT] = 1'b1;
		end
		if (sw_rst_req) begin
			cause_nxt[rcmr_pkg::CAUSE_SW_BIT] = 1'b1;
		end
	end

	// Cause register; external pin adds nothing, so zero means external
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cause_r <= rcmr_pkg::CAUSE_POR_VAL;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// Reset sequencer: hold, hidden kernel, then user code
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_r <= rcmr_pkg::RCMR_HOLD;
			hold_cnt_r <= HOLD_LOAD;
			vec_jump_r <= 1'b0;
		end else begin
			vec_jump_r <= 1'b0;
			if (rst_trig) begin // Any source restarts the sequence
				seq_r <= rcmr_pkg::RCMR_HOLD;
				hold_cnt_r <= HOLD_LOAD;
			end else begin
				unique case (seq_r)
					rcmr_pkg::RCMR_HOLD: begin
						if (hold_cnt_r == '0) begin
							seq_r <= rcmr_pkg::RCMR_KERNEL;
						end else begin
							hold_cnt_r <= hold_cnt_r - 1'b1;
						end
					end
					rcmr_pkg::RCMR_KERNEL: begin
						// Low boot pin keeps the core in the kernel for download
						if (kernel_done && boot_mode_pin) begin
							seq_r <= rcmr_pkg::RCMR_USER;
							vec_jump_r <= 1'b1;
						end
					end
					rcmr_pkg::RCMR_USER: begin
						seq_r <= rcmr_pkg::RCMR_USER;
					end
					default: begin // Unused code falls back to hold without reloading the counter
						seq_r <= rcmr_pkg::RCMR_HOLD;
					end
				endcase
			end
		end
	end

	// Core-facing levels, registered so they never glitch
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sys_rst_b_r <= 1'b0;
			kernel_mode_r <= 1'b0;
		end else begin
			sys_rst_b_r <= !rst_trig && (seq_r != rcmr_pkg::RCMR_HOLD);
			kernel_mode_r <= !rst_trig && (seq_r == rcmr_pkg::RCMR_KERNEL);
		end
	end

	// Mirror select: any reset puts flash back at the bottom
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mirror_r <= 1'b0;
		end else if (rst_trig || (seq_r == rcmr_pkg::RCMR_HOLD)) begin
			mirror_r <= 1'b0;
		end else if (bus_wr && (bus_addr == rcmr_pkg::REG_MIRROR)) begin
			mirror_r <= bus_wdata[rcmr_pkg::MIRROR_SRAM_BIT];
		end
	end

	// Access decode; uses the live select so the next access sees it
	assign dec_nxt = decode(cpu_addr, mirror_r, kernel_mode_r, MIRROR_BYTES);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dec_r <= '0;
		end else if (cpu_req) begin
			dec_r <= dec_nxt;
		end else begin
			dec_r <= '0; // Idle cycles select nothing
		end
	end

	// Events feeding the interrupt status
	always_comb begin
		evt_set = '0;
		evt_set[rcmr_pkg::EVT_USER_BIT] = vec_jump_r;
		evt_set[rcmr_pkg::EVT_FAULT_BIT] = cpu_req && dec_nxt.fault;
		evt_set[rcmr_pkg::EVT_RST_BIT] = rst_trig;
	end

	// Status is cleared by its read; a coincident event survives
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			evt_stat_r <= rcmr_pkg::EVT_RST_VAL;
		end else if (bus_rd && (bus_addr == rcmr_pkg::REG_IRQ_STAT)) begin
			evt_stat_r <= evt_set;
		end else begin
			evt_stat_r <= evt_stat_r | evt_set;
		end
	end

	// Mask register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			evt_mask_r <= rcmr_pkg::EVT_RST_VAL;
		end else if (bus_wr && (bus_addr == rcmr_pkg::REG_IRQ_MASK)) begin
			evt_mask_r <= bus_wdata[rcmr_pkg::EVT_W-1:0];
		end
	end

	// Interrupt registered from the stored status and this cycle's events
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |((evt_stat_r | evt_set) & evt_mask_r);
		end
	end

	// Read data for the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bus_rdata_r <= '0;
		end else begin
			bus_rdata_r <= '0;
			if (bus_rd) begin
				unique case (bus_addr)
					rcmr_pkg::REG_MIRROR: bus_rdata_r <= {31'h00000000, mirror_r};
					rcmr_pkg::REG_CAUSE: bus_rdata_r <= {29'h00000000, cause_r};
					rcmr_pkg::REG_IRQ_STAT: bus_rdata_r <= {29'h00000000, evt_stat_r};
					rcmr_pkg::REG_IRQ_MASK: bus_rdata_r <= {29'h00000000, evt_mask_r};
					default: bus_rdata_r <= '0; // Clear register reads zero
				endcase
			end
		end
	end

	// Checks kept beside the logic
	chk_remap_reset: assert property (@(posedge clk) disable iff (!rst_b)
		rst_trig |=> !mirror_r ##1 !mirror_r) else $error("mirror not cleared by reset");
	chk_por_flags: assert property (@(posedge clk)
		rst_b && !$past(rst_b) |-> cause_r == rcmr_pkg::CAUSE_POR_VAL) else $error("power-on flags wrong");
	chk_wdog_flag: assert property (@(posedge clk) disable iff (!rst_b)
		wdog_expire |=> cause_r[rcmr_pkg::CAUSE_WDOG_BIT] && !sys_rst_b_r) else $error("watchdog flag missing");
	chk_sw_reset: assert property (@(posedge clk) disable iff (!rst_b)
		sw_rst_req |=> cause_r[rcmr_pkg::CAUSE_SW_BIT] && (seq_r == rcmr_pkg::RCMR_HOLD)) else $error("sw reset lost");
	chk_clear_only: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && |($past(cause_r) & ~cause_r) |-> $past(clr_wr)) else $error("flag fell without clear");
	chk_ext_noflag: assert property (@(posedge clk) disable iff (!rst_b)
		!ext_rst_b && !wdog_expire && !bus_wr && (cause_r == '0) |=> cause_r == '0) else $error("external set a flag");
	chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_b)
		bus_rd && (bus_addr == rcmr_pkg::REG_CAUSE) |=> bus_rdata_r[31:3] == '0) else $error("reserved bits set");
	chk_bottom_sram: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_req && mirror_r && (cpu_addr < rcmr_pkg::VEC_TOP) |=> dec_r.sel_sram && !dec_r.sel_flash)
		else $error("vector not from SRAM");
	chk_bottom_flash: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_req && !mirror_r && (cpu_addr < rcmr_pkg::VEC_TOP) |=> dec_r.sel_flash && !dec_r.sel_sram)
		else $error("vector not from flash");
	chk_kernel_hidden: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_req && !kernel_mode_r && (cpu_addr == rcmr_pkg::KERNEL_BASE) |=> dec_r.fault && !dec_r.sel_kernel)
		else $error("kernel visible to user");
	chk_boot_jump: assert property (@(posedge clk) disable iff (!rst_b)
		(seq_r == rcmr_pkg::RCMR_KERNEL) && kernel_done && boot_mode_pin && !rst_trig
		|=> vec_jump_r ##1 (seq_r == rcmr_pkg::RCMR_USER) && !kernel_mode_r) else $error("no jump to vector");

	// Power-on reset leaves flash at the bottom and only the power-on flag
	chk_por_state: assert property (@(posedge clk)
		!rst_b |=> !mirror_r && (cause_r == rcmr_pkg::CAUSE_POR_VAL) && !sys_rst_b_r)
		else $error("power-on state wrong");

	// A legal write of one maps SRAM in at the next edge
	chk_mirror_set: assert property (@(posedge clk) disable iff (!rst_b)
		bus_wr && (bus_addr == rcmr_pkg::REG_MIRROR) && bus_wdata[0] && !rst_trig && (seq_r != rcmr_pkg::RCMR_HOLD)
		|=> mirror_r) else $error("mirror set lost");

	// A write of zero maps flash back; the swap is reversible
	chk_mirror_clr: assert property (@(posedge clk) disable iff (!rst_b)
		bus_wr && (bus_addr == rcmr_pkg::REG_MIRROR) && !bus_wdata[0]
		|=> !mirror_r) else $error("mirror clear lost");

	// Core stays in reset for the whole hold
	chk_hold_sysrst: assert property (@(posedge clk) disable iff (!rst_b)
		(seq_r == rcmr_pkg::RCMR_HOLD) |=> !sys_rst_b_r)
		else $error("core released during hold");

	// External pin restarts the hold at once
	chk_ext_restart: assert property (@(posedge clk) disable iff (!rst_b)
		!ext_rst_b |=> (seq_r == rcmr_pkg::RCMR_HOLD) && !sys_rst_b_r)
		else $error("external reset ignored");

	// Without a clear write no flag may fall, whatever non power-on reset comes
	chk_flags_kept: assert property (@(posedge clk) disable iff (!rst_b)
		!clr_wr |=> (cause_r & $past(cause_r)) == $past(cause_r))
		else $error("flag lost without clear");

	// Software reset drops the core and the hidden code at once
	chk_sw_restart: assert property (@(posedge clk) disable iff (!rst_b)
		sw_rst_req |=> !sys_rst_b_r && !kernel_mode_r)
		else $error("sw reset left core running");

	// Clear register is write only and reads zero
	chk_clear_reads: assert property (@(posedge clk) disable iff (!rst_b)
		bus_rd && (bus_addr == rcmr_pkg::REG_CAUSE_CLR) |=> bus_rdata_r == '0)
		else $error("clear register read nonzero");

	// Hidden code is reachable while the kernel runs
	chk_kernel_seen: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_req && kernel_mode_r && (cpu_addr == rcmr_pkg::KERNEL_BASE) |=> dec_r.sel_kernel && !dec_r.fault)
		else $error("kernel refused to itself");

	// SRAM is smaller than the window; the gap above it is refused
	chk_sram_gap: assert property (@(posedge clk) disable iff (!rst_b)
		cpu_req && mirror_r && (cpu_addr >= rcmr_pkg::SRAM_BYTES) && (cpu_addr < MIRROR_BYTES)
		|=> dec_r.fault) else $error("SRAM gap not refused");

	// Jump is a single pulse
	chk_jump_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		vec_jump_r |=> !vec_jump_r)
		else $error("jump pulse too long");

	// Low boot pin keeps the core in the kernel
	chk_kernel_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(seq_r == rcmr_pkg::RCMR_KERNEL) && !boot_mode_pin && !rst_trig |=> seq_r == rcmr_pkg::RCMR_KERNEL)
		else $error("left kernel with pin low");

	// Idle cycles select no memory at all
	chk_idle_dec: assert property (@(posedge clk) disable iff (!rst_b)
		!cpu_req |=> dec_r == '0)
		else $error("decode without request");

	// Read data stand only after a read strobe
	chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!bus_rd |=> bus_rdata_r == '0)
		else $error("read data without strobe");
endmodule : rcmr_top
`default_nettype wire

// File: bench/rcmr_core_model.sv
// Core model: runs the kernel setup and fetches the reset vector
`timescale 1ns/1ps
`default_nettype none
module rcmr_core_model (
	input wire logic clk, // System clock
	input wire logic rst_b, // Power-on reset
	input wire logic kernel_mode_r, // Core runs hidden code
	input wire logic vec_jump_r, // Jump to reset vector
	input wire logic tb_req, // Bench access valid
	input wire logic [31:0] tb_addr, // Bench access address
	output logic cpu_req, // Access valid
	output logic [31:0] cpu_addr, // Access address
	output logic kernel_done // Kernel setup finished
);
	logic [1:0] setup_r = 2'h0; // Kernel setup progress
	logic vec_fetch_r = 1'b0; // Vector fetch this cycle
	initial kernel_done = 1'b0;
	// Kernel setup takes a few cycles, then reports done once
	always @(posedge clk) begin
		if (!rst_b || !kernel_mode_r) begin
			setup_r <= 2'h0;
		end else if (setup_r != 2'h3) begin
			setup_r <= setup_r + 2'h1;
		end
		kernel_done <= rst_b && kernel_mode_r && (setup_r == 2'h2);
		vec_fetch_r <= rst_b && vec_jump_r;
	end
	// The reset handler is fetched from the bottom, where flash must sit
	assign cpu_req = tb_req | vec_fetch_r;
	assign cpu_addr = vec_fetch_r ? rcmr_pkg::RESET_VECTOR : tb_addr;
endmodule : rcmr_core_model
`default_nettype wire

// File: bench/testbench.sv
// Bench for the reset cause and memory remap block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0; // 10 MHz clock
	logic rst_b = 1'b0; // Power-on reset
	logic ext_rst_b = 1'b1; // External reset pin
	logic wdog_expire = 1'b0; // Watchdog pulse
	logic boot_mode_pin = 1'b1; // Normal boot
	logic [7:0] bus_addr = 8'h00; // Register address
	logic [31:0] bus_wdata = 32'h00000000; // Write data
	logic bus_wr = 1'b0; // Write strobe
	logic bus_rd = 1'b0; // Read strobe
	logic tb_req = 1'b0; // Bench core access
	logic [31:0] tb_addr = 32'h00000000; // Bench core address
	logic [31:0] bus_rdata_r; // Read data
	rcmr_pkg::rcmr_dec_t dec_r; // Decode answer
	logic sys_rst_b_r, kernel_mode_r, vec_jump_r, irq_r; // Sequencer and interrupt
	logic cpu_req, kernel_done; // From core model
	logic [31:0] cpu_addr; // From core model
	int err_count = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	// Short hold keeps every reset cheap
	rcmr_top #(.MIRROR_BYTES(rcmr_pkg::MIRROR_BYTES), .HOLD_CYC(2)) DUT (.clk(clk), .rst_b(rst_b),
		.ext_rst_b(ext_rst_b), .wdog_expire(wdog_expire), .boot_mode_pin(boot_mode_pin),
		.kernel_done(kernel_done), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .dec_r(dec_r),
		.sys_rst_b_r(sys_rst_b_r), .kernel_mode_r(kernel_mode_r), .vec_jump_r(vec_jump_r), .irq_r(irq_r));
	rcmr_core_model core (.clk(clk), .rst_b(rst_b), .kernel_mode_r(kernel_mode_r), .vec_jump_r(vec_jump_r),
		.tb_req(tb_req), .tb_addr(tb_addr), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .kernel_done(kernel_done));
	// Clock
	initial begin
		forever #50 clk = ~clk;
	end
	// Masked compare of seen against expected
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input logic [35:0] msk = '1);
		samples_checked++;
		if ((seen & msk) !== (exp & msk)) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen & msk, exp & msk);
		end
	endtask : chk
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : wr
	// Read; data stand only in the next cycle
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk = '1);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		chk({4'h0, bus_rdata_r}, {4'h0, exp}, {4'h0, msk});
	endtask : rdc
	// Core access and its decode answer
	task automatic fetch(input logic [31:0] a, input logic [35:0] exp, input logic [35:0] msk = '1);
		@(posedge clk);
		tb_req <= 1'b1;
		tb_addr <= a;
		@(posedge clk);
		tb_req <= 1'b0;
		#1;
		chk(dec_r, exp, msk);
	endtask : fetch
	// Wait for the jump to user code, bounded
	task automatic boot();
		int n;
		n = 0;
		while (vec_jump_r !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({35'h0, vec_jump_r}, 36'h1);
		@(posedge clk);
		#1;
		chk({35'h0, kernel_mode_r}, 36'h0);
		@(posedge clk);
		#1;
		chk(dec_r, {4'h8, 32'h0});
		chk({35'h0, sys_rst_b_r}, 36'h1);
	endtask : boot
	task automatic t_por();
		boot();
		rdc(rcmr_pkg::REG_CAUSE, 32'h1);
		rdc(rcmr_pkg::REG_MIRROR, 32'h0);
		rdc(8'h20, 32'h0);
		$display("t_por done");
	endtask : t_por
	task automatic t_mirror();
		fetch(32'h00080020, {4'h8, 32'h20});
		wr(rcmr_pkg::REG_MIRROR, 32'h1);
		fetch(32'h4, {4'h4, 32'h4});
		rdc(rcmr_pkg::REG_MIRROR, 32'h1);
		fetch(32'h00080020, {4'h8, 32'h20});
		wr(rcmr_pkg::REG_MIRROR, 32'h0);
		fetch(32'h4, {4'h8, 32'h4});
		$display("t_mirror done");
	endtask : t_mirror
	task automatic t_cause();
		wr(rcmr_pkg::REG_MIRROR, 32'h1);
		@(posedge clk);
		wdog_expire <= 1'b1;
		@(posedge clk);
		wdog_expire <= 1'b0;
		#1;
		chk({35'h0, sys_rst_b_r}, 36'h0);
		boot();
		rdc(rcmr_pkg::REG_CAUSE, 32'h3);
		rdc(rcmr_pkg::REG_MIRROR, 32'h0);
		wr(rcmr_pkg::REG_CAUSE_CLR, 32'h2);
		rdc(rcmr_pkg::REG_CAUSE, 32'h1);
		wr(rcmr_pkg::REG_CAUSE, 32'h0);
		rdc(rcmr_pkg::REG_CAUSE, 32'h1);
		wr(rcmr_pkg::REG_CAUSE_CLR, 32'h1);
		@(posedge clk);
		ext_rst_b <= 1'b0;
		@(posedge clk);
		ext_rst_b <= 1'b1;
		boot();
		rdc(rcmr_pkg::REG_CAUSE, 32'h0);
		wr(rcmr_pkg::REG_CAUSE, 32'hFC);
		boot();
		rdc(rcmr_pkg::REG_CAUSE, 32'h4);
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		boot();
		rdc(rcmr_pkg::REG_CAUSE, 32'h1);
		$display("t_cause done");
	endtask : t_cause
	task automatic t_irq();
		rdc(rcmr_pkg::REG_IRQ_STAT, 32'h1);
		rdc(rcmr_pkg::REG_IRQ_STAT, 32'h0);
		wr(rcmr_pkg::REG_IRQ_MASK, 32'h0);
		fetch(rcmr_pkg::KERNEL_BASE, 36'h1_0000_0000, 36'h1_0000_0000);
		@(posedge clk);
		#1;
		chk({35'h0, irq_r}, 36'h0);
		wr(rcmr_pkg::REG_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk);
		#1;
		chk({35'h0, irq_r}, 36'h1);
		rdc(rcmr_pkg::REG_IRQ_STAT, 32'h2, 32'h2);
		repeat (2) @(posedge clk);
		#1;
		chk({35'h0, irq_r}, 36'h0);
		$display("t_irq done");
	endtask : t_irq
	// Verdict and end of run
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	// Main sequence after a 4-cycle reset
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_por();
		t_mirror();
		t_cause();
		t_irq();
		end_sim();
	end
	// Hang guard, far beyond the 120 or so cycles needed
	initial begin
		#3000000;
		err_count++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
